// ---- cmpd_control_mode_pin_decoder.sv ----
/*
 control mode pin decoder: filters the tri-level strap pins, chooses
 pin-programmed or extended (serial) control, decodes the settings and
 routes the three shared pins to the serial port; also makes the output
 data clock and its data-change strobe from the sample clock.
 assumes straps synchronous to clk and clk equal to the sample clock.
*/
// Operation
// R1: primary enable high forces pin-programmed mode, serial port inactive.
// R2: primary floating, secondary floating/high: range pin floating picks extended.
// R3: extended when primary low, or range pin floating, secondary not low.
// R4: pin mode: range pin low reduced range, high normal range.
// R5: host drives level pin firmly; low reduced swing, high normal.
// R6: pin mode: edge pin high positive edge, low negative edge.
// R7: edge pin floating selects double data rate, edge ignored.
// R8: pin mode: delay pin low short, high long calibration delay.
// R9: extended: level pin clock, edge pin data, delay pin chip select.
// R10: host writes all nine registers before calibration or use.
// R11: single rate: data changes on rising edge if select high, else falling.
// R12: double rate: output clock is one quarter of sample clock.
// R13: each strap resolves low, high or floating; settings track changes.
// R14: strap accepted only after holding stable several cycles.
`timescale 1ns/1ns
module cmpd_control_mode_pin_decoder
    import cmpd_pkg::*;
(
    input  wire logic               clk,
    input  wire logic               rst,
    input  cmpd_pkg::cmpd_straps_t  straps,
    output cmpd_pkg::cmpd_settings_t settings,
    output logic                    serialActive,
    output cmpd_pkg::cmpd_serial_t  serialPort,
    output logic                    outputDataClock,
    output logic                    dataChange
);
    typedef struct packed {
        cmpd_settings_t settings;
        cmpd_serial_t   serial;
        logic           divCount;
        logic           outClock;
    } cmpd_top_state_t;

    cmpd_level_t     primaryLvl;
    cmpd_level_t     secondaryLvl;
    cmpd_level_t     rangeLvl;
    cmpd_level_t     levelLvl;
    cmpd_level_t     edgeLvl;
    cmpd_level_t     delayLvl;
    cmpd_top_state_t state_q;
    cmpd_top_state_t state_d;
    logic            secondaryOk;
    logic            extended;
    logic            clockEdge;

    // ========================================
    // strap filters
    cmpd_pin_filter uPrimary (.clk(clk), .rst(rst),
        .pinRaw(straps.primaryEnable), .pinStable(primaryLvl));
    cmpd_pin_filter uSecondary (.clk(clk), .rst(rst),
        .pinRaw(straps.secondarySelect), .pinStable(secondaryLvl));
    cmpd_pin_filter uRange (.clk(clk), .rst(rst),
        .pinRaw(straps.rangePin), .pinStable(rangeLvl));
    cmpd_pin_filter uLevel (.clk(clk), .rst(rst),
        .pinRaw(straps.levelPin), .pinStable(levelLvl));
    cmpd_pin_filter uEdge (.clk(clk), .rst(rst),
        .pinRaw(straps.edgePin), .pinStable(edgeLvl));
    cmpd_pin_filter uDelay (.clk(clk), .rst(rst),
        .pinRaw(straps.delayPin), .pinStable(delayLvl));

    // ========================================
    // mode decode
    always_comb begin
        secondaryOk = (secondaryLvl != LVL_LOW);
        extended    = 1'b0;
        if (primaryLvl == LVL_HIGH) begin
            extended = 1'b0; // R1
        end else if (primaryLvl == LVL_LOW) begin
            extended = secondaryOk; // R3
        end else begin
            extended = secondaryOk && (rangeLvl == LVL_FLOAT); // R2 R3
        end
    end

    // ========================================
    // settings and output clock
    always_comb begin
        state_d = state_q;
        state_d.settings.extendedMode = extended;
        if (extended) begin
            // shared pins belong to the serial port
            state_d.serial.serialClock         = straps.levelPin.level; // R9
            state_d.serial.serialDataPin       = straps.edgePin.level; // R9
            state_d.serial.serialChipSelectPin = straps.delayPin.level; // R9
        end else begin
            state_d.serial = '0;
            state_d.settings.reducedRange = (rangeLvl == LVL_LOW); // R4
            // floating level pin is undefined: keep the last setting
            if (levelLvl != LVL_FLOAT) begin
                state_d.settings.reducedSwing = (levelLvl == LVL_LOW); // R5
            end
            state_d.settings.doubleDataRate = (edgeLvl == LVL_FLOAT); // R7
            if (edgeLvl != LVL_FLOAT) begin
                state_d.settings.outputEdgeSelect = (edgeLvl == LVL_HIGH); // R6
            end
            if (delayLvl != LVL_FLOAT) begin
                state_d.settings.calibrationDelayLong =
                    (delayLvl == LVL_HIGH); // R8
            end
        end
        if (state_q.settings.doubleDataRate) begin
            // toggle every two samples: quarter of the sample rate
            state_d.divCount = ~state_q.divCount; // R12
            if (state_q.divCount == DDR_DIV_LAST) begin
                state_d.outClock = ~state_q.outClock; // R12
            end
        end else begin
            state_d.divCount = 1'b0;
            state_d.outClock = ~state_q.outClock;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state_q <= '{settings: SETTINGS_RESET, serial: '0,
                         divCount: 1'b0, outClock: 1'b0};
        end else begin
            state_q <= state_d;
        end
    end

    // ========================================
    // outputs
    always_comb begin
        clockEdge = 1'b0;
        if (state_q.settings.doubleDataRate) begin
            clockEdge = (state_q.divCount == DDR_DIV_LAST); // R7
        end else if (state_q.settings.outputEdgeSelect) begin
            clockEdge = ~state_q.outClock; // R11
        end else begin
            clockEdge = state_q.outClock; // R11
        end
    end

    assign settings        = state_q.settings;
    assign serialActive    = state_q.settings.extendedMode;
    assign serialPort      = state_q.serial;
    assign outputDataClock = state_q.outClock;
    assign dataChange      = clockEdge;

    // ========================================
    // checks
    AST_PRIMARY_HIGH: assert property ( // R1
        @(posedge clk) disable iff (rst)
        primaryLvl == LVL_HIGH |=> !serialActive)
        else $error("extended mode with primary enable high");
    AST_SERIAL_IDLE: assert property ( // R1
        @(posedge clk) disable iff (rst)
        !extended |=> serialPort == '0)
        else $error("serial port active in pin mode");
    AST_RANGE_FLOAT: assert property ( // R2
        @(posedge clk) disable iff (rst)
        primaryLvl == LVL_FLOAT && secondaryLvl != LVL_LOW
        && rangeLvl == LVL_FLOAT |=> serialActive)
        else $error("floating range pin did not select extended mode");
    AST_PRIMARY_LOW: assert property ( // R3
        @(posedge clk) disable iff (rst)
        primaryLvl == LVL_LOW && secondaryLvl != LVL_LOW
        |=> serialActive)
        else $error("primary low did not select extended mode");
    AST_RANGE: assert property ( // R4
        @(posedge clk) disable iff (rst)
        !extended && rangeLvl != LVL_FLOAT |=>
            settings.reducedRange == $past(rangeLvl == LVL_LOW))
        else $error("full scale range wrong");
    AST_SWING: assert property ( // R5
        @(posedge clk) disable iff (rst)
        !extended && levelLvl != LVL_FLOAT |=>
            settings.reducedSwing == $past(levelLvl == LVL_LOW))
        else $error("output swing wrong");
    AST_EDGE: assert property ( // R6
        @(posedge clk) disable iff (rst)
        !extended && edgeLvl == LVL_HIGH |=>
            settings.outputEdgeSelect && !settings.doubleDataRate)
        else $error("edge select wrong");
    AST_EDGE_NEG: assert property ( // R6
        @(posedge clk) disable iff (rst)
        !extended && edgeLvl == LVL_LOW |=>
            !settings.outputEdgeSelect && !settings.doubleDataRate)
        else $error("negative edge not selected");
    AST_DDR: assert property ( // R7
        @(posedge clk) disable iff (rst)
        !extended && edgeLvl == LVL_FLOAT |=> settings.doubleDataRate)
        else $error("floating edge pin did not select double rate");
    AST_DDR_STROBE: assert property ( // R7
        @(posedge clk) disable iff (rst)
        settings.doubleDataRate && dataChange |=>
            $changed(outputDataClock))
        else $error("double rate data change without clock edge");
    AST_DELAY: assert property ( // R8
        @(posedge clk) disable iff (rst)
        !extended && delayLvl == LVL_LOW |=>
            !settings.calibrationDelayLong)
        else $error("calibration delay wrong");
    AST_DELAY_LONG: assert property ( // R8
        @(posedge clk) disable iff (rst)
        !extended && delayLvl == LVL_HIGH |=>
            settings.calibrationDelayLong)
        else $error("long calibration delay not selected");
    AST_SERIAL: assert property ( // R9
        @(posedge clk) disable iff (rst)
        extended |=> serialPort == $past({straps.levelPin.level,
            straps.edgePin.level, straps.delayPin.level}))
        else $error("serial pins not routed");
    AST_SDR_EDGE: assert property ( // R11
        @(posedge clk) disable iff (rst)
        !settings.doubleDataRate && dataChange |->
            outputDataClock != settings.outputEdgeSelect)
        else $error("data change on wrong clock edge");
    // a mode change inside the window ends the quarter rate legally
    AST_QUARTER: assert property ( // R12
        @(posedge clk) disable iff (rst)
        settings.doubleDataRate && $past(settings.doubleDataRate, 4)
        && $rose(outputDataClock) |->
            ##2 ($fell(outputDataClock) || !settings.doubleDataRate)
            ##2 ($rose(outputDataClock) || !settings.doubleDataRate))
        else $error("double rate clock not a quarter rate");
    AST_TRACK: assert property ( // R13
        @(posedge clk) disable iff (rst)
        $changed(primaryLvl) ##1 $stable(primaryLvl)
        |-> serialActive == $past(extended))
        else $error("mode did not follow strap");

    COV_EXT: cover property (@(posedge clk) $rose(serialActive));
    COV_DDR: cover property (@(posedge clk) $rose(settings.doubleDataRate));
    COV_BACK: cover property (@(posedge clk) $fell(serialActive));
    COV_SDR_NEG: cover property (@(posedge clk)
        !settings.doubleDataRate && !settings.outputEdgeSelect && dataChange);
    COV_BURST: cover property (@(posedge clk)
        serialActive && $fell(serialPort.serialChipSelectPin));

endmodule // cmpd_control_mode_pin_decoder

// ---- cmpd_pin_filter.sv ----
/*
 one tri-level strap filter: a resolved level is accepted only after
 it has held unchanged for the filter length.
 assumes straps synchronous to clk.
*/
`timescale 1ns/1ns
module cmpd_pin_filter
    import cmpd_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst,
    input  cmpd_pkg::cmpd_pin_t pinRaw,
    output cmpd_pkg::cmpd_level_t pinStable
);
    typedef struct packed {
        cmpd_level_t candidate;
        cmpd_level_t accepted;
        logic [2:0]  count;
    } cmpd_filt_state_t;

    cmpd_filt_state_t state_q;
    cmpd_filt_state_t state_d;
    cmpd_level_t      sampled;

    // ========================================
    // filter
    always_comb begin
        sampled = cmpd_resolve(pinRaw); // R13
        state_d = state_q;
        if (sampled != state_q.candidate) begin
            state_d.candidate = sampled;
            state_d.count     = STABLE_RESET;
        end else if (state_q.count != STABLE_LAST) begin
            state_d.count = state_q.count + 3'h1;
        end else begin
            state_d.accepted = state_q.candidate; // R14
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state_q <= '{candidate: LVL_FLOAT, accepted: LVL_FLOAT,
                         count: STABLE_RESET};
        end else begin
            state_q <= state_d;
        end
    end

    assign pinStable = state_q.accepted;

    // ========================================
    // checks
    AST_FILTER_HOLDS: assert property ( // R14
        @(posedge clk) disable iff (rst)
        $changed(state_q.accepted) |->
            $past(sampled, 1) == state_q.accepted
            && $past(sampled, 4) == state_q.accepted
            && $past(sampled, 5) == state_q.accepted)
        else $error("strap accepted before it was stable");

endmodule // cmpd_pin_filter

// ---- cmpd_pkg.sv ----
/*
 package for the control mode pin decoder: tri-level pin states, decoded
 settings struct, filter length and output clock divider constants.
 assumes nothing of its surroundings.
*/
package cmpd_pkg;

    // resolved level of a tri-level strap pin
    typedef enum logic [1:0] {
        LVL_LOW   = 2'b00,
        LVL_HIGH  = 2'b01,
        LVL_FLOAT = 2'b10
    } cmpd_level_t;

    // raw pin sense: drive level plus a separate "pin is driven" detect
    typedef struct packed {
        logic level;
        logic driven;
    } cmpd_pin_t;

    typedef struct packed {
        cmpd_pin_t primaryEnable;
        cmpd_pin_t secondarySelect;
        cmpd_pin_t rangePin;
        cmpd_pin_t levelPin;
        cmpd_pin_t edgePin;
        cmpd_pin_t delayPin;
    } cmpd_straps_t;

    // decoded settings
    typedef struct packed {
        logic extendedMode;
        logic reducedRange;
        logic reducedSwing;
        logic outputEdgeSelect;
        logic doubleDataRate;
        logic calibrationDelayLong;
    } cmpd_settings_t;

    // serial port routing in extended mode
    typedef struct packed {
        logic serialClock;
        logic serialDataPin;
        logic serialChipSelectPin;
    } cmpd_serial_t;

    localparam int unsigned STABLE_CYCLES = 4;
    localparam logic [2:0]  STABLE_LAST   = 3'h3;
    localparam logic [2:0]  STABLE_RESET  = 3'h0;
    // output clock toggles every second sample: period is four samples
    localparam logic        DDR_DIV_LAST  = 1'h1;

    localparam cmpd_settings_t SETTINGS_RESET = '{
        extendedMode:         1'b0,
        reducedRange:         1'b0,
        reducedSwing:         1'b0,
        outputEdgeSelect:     1'b1,
        doubleDataRate:       1'b0,
        calibrationDelayLong: 1'b0
    };

    function automatic cmpd_level_t cmpd_resolve(input cmpd_pin_t p);
        cmpd_level_t r;
        r = LVL_FLOAT;
        if (p.driven) begin
            r = p.level ? LVL_HIGH : LVL_LOW;
        end
        return r;
    endfunction

endpackage

// ---- cmpd_strap_model.sv ----
/*
 board side model: drives the six strap pins from a requested value and,
 on request, plays nine serial write frames on the shared pins.
 assumes the requested straps change only at clk rising edges.
*/
`timescale 1ns/1ns
module cmpd_strap_model
    import cmpd_pkg::*;
#(
    parameter int unsigned FRAME_BITS = 16,
    parameter int unsigned FRAMES     = 9
)
(
    input  wire logic             clk,
    input  wire logic             rst,
    input  cmpd_pkg::cmpd_straps_t want,
    input  wire logic             burst,
    output cmpd_pkg::cmpd_straps_t straps,
    output logic                  busy
);
    typedef struct packed {
        cmpd_straps_t pins;
        logic [7:0]   bitCnt;
        logic [3:0]   frameCnt;
        logic         busy;
    } cmpd_model_state_t;

    cmpd_model_state_t s_q;
    cmpd_model_state_t s_d;

    // ==========================================================
    // pin drive
    always_comb begin
        s_d = s_q;
        s_d.pins = want;
        s_d.pins.levelPin.driven = 1'b1;
        if (burst && !s_q.busy) begin
            s_d.busy = 1'b1;
            s_d.bitCnt = 8'h00;
            s_d.frameCnt = 4'h0;
        end
        if (s_q.busy) begin
            // chip select low, clock and data on the shared pins
            s_d.pins.delayPin = '{level: 1'b0, driven: 1'b1};
            s_d.pins.levelPin.level = s_q.bitCnt[0];
            s_d.pins.edgePin = '{level: s_q.bitCnt[1] ^ s_q.frameCnt[0],
                                 driven: 1'b1};
            s_d.bitCnt = s_q.bitCnt + 8'h01;
            if (s_q.bitCnt == 8'(2 * FRAME_BITS - 1)) begin
                s_d.bitCnt = 8'h00;
                s_d.frameCnt = s_q.frameCnt + 4'h1;
                if (s_q.frameCnt == 4'(FRAMES - 1)) begin
                    s_d.busy = 1'b0;
                end
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign straps = s_q.pins;
    assign busy   = s_q.busy;
endmodule // cmpd_strap_model

// ---- tb_top.sv ----
/*
 testbench for the control mode pin decoder: corner straps, random
 straps, glitches, serial burst, output clock and reset checks.
 assumes the strap model beside it and a 50 MHz clock.
*/
`timescale 1ns/1ns
module tb_top;
    import cmpd_pkg::*;

    logic           clk = 1'b0;
    logic           rst = 1'b1;
    cmpd_straps_t   want = 12'h000;
    logic           burst = 1'b0;
    cmpd_straps_t   straps;
    logic           busy;
    cmpd_settings_t settings;
    logic           serialActive;
    cmpd_serial_t   serialPort;
    logic           outputDataClock;
    logic           dataChange;
    cmpd_settings_t exp = SETTINGS_RESET;
    int             n_errors = 0;
    int             compares = 0;
    int             cycles = 0;
    int             seed = 32'h0000_c8bf;
    logic [11:0]    corners [6] = '{12'hF31, 12'h01F, 12'h7F5,
                                    12'h357, 12'h5FD, 12'h51D};

    always #10 clk = ~clk;

    cmpd_strap_model u_cmpd_strap_model (.clk(clk), .rst(rst),
        .want(want), .burst(burst), .straps(straps), .busy(busy));
    cmpd_control_mode_pin_decoder u_cmpd_control_mode_pin_decoder (
        .clk(clk), .rst(rst), .straps(straps), .settings(settings),
        .serialActive(serialActive), .serialPort(serialPort),
        .outputDataClock(outputDataClock), .dataChange(dataChange));

    // ==========================================================
    // checking
    task automatic check(input string what, input logic [7:0] e, g);
        compares++;
        if (g !== e) begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", what, e, g);
        end
    endtask

    task automatic end_of_test();
        $display("compares %0d mismatches %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    always @(posedge clk) begin
        cycles++;
        if (cycles == 30000) begin
            n_errors++;
            end_of_test();
        end
    end

    function automatic cmpd_settings_t predict(cmpd_settings_t e,
                                               cmpd_straps_t s);
        e.extendedMode = !(s.secondarySelect.driven
            && !s.secondarySelect.level)
            && ((s.primaryEnable.driven && !s.primaryEnable.level)
            || (!s.primaryEnable.driven && !s.rangePin.driven));
        if (!e.extendedMode) begin
            e.reducedRange = s.rangePin.driven && !s.rangePin.level;
            e.reducedSwing = !s.levelPin.level;
            e.doubleDataRate = !s.edgePin.driven;
            if (s.edgePin.driven) e.outputEdgeSelect = s.edgePin.level;
            if (s.delayPin.driven) e.calibrationDelayLong = s.delayPin.level;
        end
        return e;
    endfunction

    // ==========================================================
    // scenarios
    task automatic apply(input cmpd_straps_t s);
        cmpd_settings_t m;
        s.levelPin.driven = 1'b1;
        @(posedge clk);
        want <= s;
        repeat (12) @(posedge clk);
        #1;
        exp = predict(exp, s);
        m = settings;
        if (exp.doubleDataRate) m.outputEdgeSelect = exp.outputEdgeSelect;
        check("settings", 8'(exp), 8'(m));
        check("serial active", 8'(exp.extendedMode), 8'(serialActive));
        check("serial port", exp.extendedMode ? 8'({s.levelPin.level,
            s.edgePin.level, s.delayPin.level}) : 8'h00, 8'(serialPort));
    endtask

    task automatic clock_check();
        int t;
        int dc;
        int bad;
        logic prev;
        t = 0;
        dc = 0;
        bad = 0;
        @(posedge clk);
        #1 prev = outputDataClock;
        for (int i = 0; i < 8; i++) begin
            @(posedge clk);
            #1;
            if (outputDataClock !== prev) t++;
            prev = outputDataClock;
            if (dataChange === 1'b1) dc++;
            if (!exp.doubleDataRate && dataChange !== (exp.outputEdgeSelect
                ? !outputDataClock : outputDataClock)) bad++;
        end
        check("clock toggles", exp.doubleDataRate ? 8'h04 : 8'h08, 8'(t));
        check("change strobes", 8'h04, 8'(dc));
        check("edge phase", 8'h00, 8'(bad));
    endtask

    task automatic reset_check();
        @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        #1;
        check("reset settings", 8'(SETTINGS_RESET), 8'(settings));
        check("reset port", 8'h00, 8'({serialPort, outputDataClock}));
        exp = SETTINGS_RESET;
        @(posedge clk);
        rst <= 1'b0;
    endtask

    initial begin
        cmpd_straps_t s;
        int bad;
        cmpd_straps_t orig;
        logic [2:0] prevPins;
        repeat (12) @(posedge clk);
        reset_check();
        foreach (corners[i]) begin
            apply(cmpd_straps_t'(corners[i]));
            clock_check();
        end
        $display("test corners done");
        for (int i = 0; i < 40; i++) begin
            apply(cmpd_straps_t'(12'($random(seed))));
            clock_check();
            orig = want;
            s = orig;
            s.edgePin.driven = !s.edgePin.driven;
            s.rangePin.driven = !s.rangePin.driven;
            @(posedge clk);
            want <= s;
            // four glitched samples: one short of acceptance
            repeat (3) @(posedge clk);
            apply(orig);
        end
        $display("test random done");
        // chip select idles high between bursts
        apply(cmpd_straps_t'(12'h7F7));
        @(posedge clk);
        burst <= 1'b1;
        @(posedge clk);
        burst <= 1'b0;
        bad = 0;
        #1 prevPins = {straps.levelPin.level, straps.edgePin.level,
                       straps.delayPin.level};
        for (int i = 0; i < 400 && (busy || i < 2); i++) begin
            @(posedge clk);
            #1;
            if (3'(serialPort) !== prevPins) bad++;
            prevPins = {straps.levelPin.level, straps.edgePin.level,
                        straps.delayPin.level};
        end
        check("serial routing", 8'h00, 8'(bad));
        check("mode held", 8'h01, 8'(serialActive));
        $display("test serial done");
        reset_check();
        apply(cmpd_straps_t'(12'h357));
        $display("test reset done");
        end_of_test();
    end
endmodule // tb_top
